/* ldc_code_select.sv */
// Purpose: Settle converter results and pick each DAC input code
// Assumes: Register port decodes 9-bit byte addresses; tables live here
// Notes:   Table rows are read combinationally, DAC codes are registered
//
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/10ps

module ldc_code_select #(
  parameter int TABLE_DEPTH = 64,
  parameter int AGREE_NEED  = ldc_pkg::AGREE_COUNT
) (
  // Clock and reset
  input  wire logic                    i_clk,
  input  wire logic                    i_reset_n,
  // Register port
  input  wire logic [8:0]              i_addr,
  input  wire logic [7:0]              i_wdata,
  input  wire logic                    i_write,
  input  wire logic                    i_read,
  output logic      [7:0]              o_rdata,
  // Converter
  input  wire ldc_pkg::ldc_sample_type i_sample,
  output logic                         o_reference_source_select,
  output logic                         o_converter_input_select,
  // DAC channels
  output ldc_pkg::ldc_channel_type     o_channel1,
  output ldc_pkg::ldc_channel_type     o_channel2
);

  logic [7:0] ctrl0;
  logic [7:0] ctrl1;
  logic [7:0] ctrl2;
  logic [7:0] ctrl3;
  logic [7:0] ctrl4;
  logic [7:0] ctrl5;
  logic [7:0] adc_result_bits;
  logic       settled;
  logic       settled_seen;
  logic [5:0] last_upper;
  logic [2:0] agree_count;
  logic [7:0] first_lookup_table  [TABLE_DEPTH];
  logic [7:0] second_lookup_table [TABLE_DEPTH];
  logic [7:0] dac1_code;
  logic [7:0] dac2_code;

  // Field decode
  wire logic       reference_source_select  = ctrl0[ldc_pkg::CTRL0_REF_BIT];
  wire logic       converter_input_select   = ctrl0[ldc_pkg::CTRL0_INPUT_BIT];
  wire logic       conversion_filter_bypass = ctrl0[ldc_pkg::CTRL0_FILTER_BIT];
  wire logic       channel1_direction_select = ctrl0[ldc_pkg::CTRL0_DIR1_BIT];
  wire logic       channel2_direction_select = ctrl0[ldc_pkg::CTRL0_DIR2_BIT];
  wire logic [5:0] table1_row_bits          = ctrl1[ldc_pkg::ROW_BITS-1:0];
  wire logic [5:0] table2_row_bits          = ctrl2[ldc_pkg::ROW_BITS-1:0];
  wire logic [7:0] dac1_direct_byte         = ctrl3;
  wire logic [7:0] dac2_direct_byte         = ctrl4;
  wire logic       table1_row_direct_select = ctrl5[ldc_pkg::CTRL5_ROW1_BIT];
  wire logic       dac1_direct_select       = ctrl5[ldc_pkg::CTRL5_DAC1_BIT];
  wire logic       table2_row_direct_select = ctrl5[ldc_pkg::CTRL5_ROW2_BIT];
  wire logic       dac2_direct_select       = ctrl5[ldc_pkg::CTRL5_DAC2_BIT];

  // Full-scale fields; zero means the external resistor
  wire ldc_pkg::ldc_full_scale_type channel1_full_scale_select =
    ldc_pkg::ldc_full_scale_type'(ctrl5[ldc_pkg::CTRL5_FS1_LSB +: 2]);
  wire ldc_pkg::ldc_full_scale_type channel2_full_scale_select =
    ldc_pkg::ldc_full_scale_type'(ctrl5[ldc_pkg::CTRL5_FS2_LSB +: 2]);

  // Register port decode
  wire logic hit_ctrl0 = i_addr == ldc_pkg::ADDR_CTRL0;
  wire logic hit_ctrl1 = i_addr == ldc_pkg::ADDR_CTRL1;
  wire logic hit_ctrl2 = i_addr == ldc_pkg::ADDR_CTRL2;
  wire logic hit_ctrl3 = i_addr == ldc_pkg::ADDR_CTRL3;
  wire logic hit_ctrl4 = i_addr == ldc_pkg::ADDR_CTRL4;
  wire logic hit_ctrl5 = i_addr == ldc_pkg::ADDR_CTRL5;
  wire logic hit_stat  = i_addr == ldc_pkg::ADDR_STATUS;
  wire logic hit_tab1  = i_addr >= ldc_pkg::TABLE1_BASE && i_addr < ldc_pkg::TABLE2_BASE;
  wire logic hit_tab2  = i_addr >= ldc_pkg::TABLE2_BASE && i_addr < ldc_pkg::TABLE_END;
  wire logic [8:0] tab1_off = i_addr - ldc_pkg::TABLE1_BASE;
  wire logic [8:0] tab2_off = i_addr - ldc_pkg::TABLE2_BASE;
  wire logic [5:0] tab1_idx = tab1_off[5:0];
  wire logic [5:0] tab2_idx = tab2_off[5:0];

  // Settling filter; upper six bits only are compared
  wire logic [5:0] sample_upper = i_sample.code[7:8-ldc_pkg::ROW_BITS];
  wire logic       upper_same   = settled_seen && sample_upper == last_upper;
  wire logic [2:0] next_agree   = upper_same ? agree_count + 3'h1 : 3'h1;
  wire logic       agree_done   = next_agree >= 3'(AGREE_NEED);
  wire logic       take_sample  = i_sample.valid &&
                                  (conversion_filter_bypass || agree_done);

  // Row selection and table byte addresses
  wire logic [5:0] adc_row   = adc_result_bits[7:8-ldc_pkg::ROW_BITS];
  wire logic [5:0] row1      = table1_row_direct_select ? table1_row_bits : adc_row;
  wire logic [5:0] row2      = table2_row_direct_select ? table2_row_bits : adc_row;
  wire logic [8:0] row1_addr = ldc_pkg::TABLE1_BASE + {3'h0, row1};
  wire logic [8:0] row2_addr = ldc_pkg::TABLE2_BASE + {3'h0, row2};
  wire logic [8:0] row1_off  = row1_addr - ldc_pkg::TABLE1_BASE;
  wire logic [8:0] row2_off  = row2_addr - ldc_pkg::TABLE2_BASE;
  wire logic [7:0] row1_byte = first_lookup_table[row1_off[5:0]];
  wire logic [7:0] row2_byte = second_lookup_table[row2_off[5:0]];

  // A direct table row does not depend on the converter, so it is live at once
  wire logic ch1_ready = dac1_direct_select || table1_row_direct_select || settled;
  wire logic ch2_ready = dac2_direct_select || table2_row_direct_select || settled;
  wire logic [7:0] next_dac1 = !ch1_ready ? ldc_pkg::DAC_IDLE_CODE :
                               dac1_direct_select ? dac1_direct_byte : row1_byte;
  wire logic [7:0] next_dac2 = !ch2_ready ? ldc_pkg::DAC_IDLE_CODE :
                               dac2_direct_select ? dac2_direct_byte : row2_byte;

  // Read data mux
  wire logic [7:0] next_rdata =
    hit_ctrl0 ? ctrl0 :
    hit_ctrl1 ? ctrl1 :
    hit_ctrl2 ? ctrl2 :
    hit_ctrl3 ? ctrl3 :
    hit_ctrl4 ? ctrl4 :
    hit_ctrl5 ? ctrl5 :
    hit_stat  ? adc_result_bits :
    hit_tab1  ? first_lookup_table[tab1_idx] :
    hit_tab2  ? second_lookup_table[tab2_idx] : ldc_pkg::REG_RESET;

  // Control registers
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctrl0 <= ldc_pkg::REG_RESET;
      ctrl1 <= ldc_pkg::REG_RESET;
      ctrl2 <= ldc_pkg::REG_RESET;
      ctrl3 <= ldc_pkg::REG_RESET;
      ctrl4 <= ldc_pkg::REG_RESET;
      ctrl5 <= ldc_pkg::REG_RESET;
    end else if (i_write) begin
      if (hit_ctrl0) ctrl0 <= i_wdata;
      if (hit_ctrl1) ctrl1 <= i_wdata;
      if (hit_ctrl2) ctrl2 <= i_wdata;
      if (hit_ctrl3) ctrl3 <= i_wdata;
      if (hit_ctrl4) ctrl4 <= i_wdata;
      if (hit_ctrl5) ctrl5 <= i_wdata;
    end
  end

  // Tables have no reset; each written independently
  always_ff @(posedge i_clk) begin
    if (i_write && hit_tab1) first_lookup_table[tab1_idx] <= i_wdata;
    if (i_write && hit_tab2) second_lookup_table[tab2_idx] <= i_wdata;
  end

  // Filter state and settled result
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      adc_result_bits <= ldc_pkg::ADC_MIN_CODE;
      settled         <= 1'b0;
      settled_seen    <= 1'b0;
      last_upper      <= 6'h00;
      agree_count     <= 3'h0;
    end else begin
      if (i_sample.valid) begin
        settled_seen <= 1'b1;
        last_upper   <= sample_upper;
        agree_count  <= agree_done ? 3'(AGREE_NEED) : next_agree;
      end
      if (take_sample) begin
        adc_result_bits <= i_sample.code;
        settled         <= 1'b1;
      end
    end
  end

  // DAC codes and read data
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      dac1_code <= ldc_pkg::DAC_IDLE_CODE;
      dac2_code <= ldc_pkg::DAC_IDLE_CODE;
      o_rdata   <= ldc_pkg::REG_RESET;
    end else begin
      dac1_code <= next_dac1;
      dac2_code <= next_dac2;
      o_rdata   <= i_read ? next_rdata : ldc_pkg::REG_RESET;
    end
  end

  assign o_reference_source_select = reference_source_select;
  assign o_converter_input_select  = converter_input_select;
  assign o_channel1 = '{dac_code: dac1_code, direction_source: channel1_direction_select,
                        full_scale_select: channel1_full_scale_select};
  assign o_channel2 = '{dac_code: dac2_code, direction_source: channel2_direction_select,
                        full_scale_select: channel2_full_scale_select};

endmodule : ldc_code_select

/* ldc_pkg.sv */
// Purpose: Shared constants and types for the look-up table DAC code selector
// Assumes: Byte-wide register port, one 100 MHz clock
// Notes:   Register indices follow the memory map byte addresses

package ldc_pkg;

  // Register byte addresses
  localparam logic [8:0] ADDR_CTRL0  = 9'h080;
  localparam logic [8:0] ADDR_CTRL1  = 9'h081;
  localparam logic [8:0] ADDR_CTRL2  = 9'h082;
  localparam logic [8:0] ADDR_CTRL3  = 9'h083;
  localparam logic [8:0] ADDR_CTRL4  = 9'h084;
  localparam logic [8:0] ADDR_CTRL5  = 9'h085;
  localparam logic [8:0] ADDR_STATUS = 9'h087;
  localparam logic [8:0] TABLE1_BASE = 9'h090;
  localparam logic [8:0] TABLE2_BASE = 9'h0d0;
  localparam logic [8:0] TABLE_END   = 9'h110;

  // Control register 0 field positions
  localparam int CTRL0_REF_BIT    = 0;
  localparam int CTRL0_INPUT_BIT  = 1;
  localparam int CTRL0_FILTER_BIT = 2;
  localparam int CTRL0_DIR1_BIT   = 3;
  localparam int CTRL0_DIR2_BIT   = 4;

  // Control register 5 field positions
  localparam int CTRL5_FS1_LSB  = 0;
  localparam int CTRL5_FS2_LSB  = 2;
  localparam int CTRL5_ROW1_BIT = 4;
  localparam int CTRL5_DAC1_BIT = 5;
  localparam int CTRL5_ROW2_BIT = 6;
  localparam int CTRL5_DAC2_BIT = 7;

  // Reset values and figures
  localparam logic [7:0] REG_RESET     = 8'h00;
  localparam logic [7:0] DAC_IDLE_CODE = 8'h00;
  localparam logic [7:0] ADC_MIN_CODE  = 8'h00;
  localparam logic [7:0] ADC_FULL_CODE = 8'hff;
  localparam int         ROW_BITS      = 6;
  localparam int         AGREE_COUNT   = 4;

  // Full-scale resistor choices
  typedef enum logic [1:0] {
    LDC_FS_EXTERNAL = 2'b00,
    LDC_FS_LOW      = 2'b01,
    LDC_FS_MIDDLE   = 2'b10,
    LDC_FS_HIGH     = 2'b11
  } ldc_full_scale_type;

  // Analog-facing settings of one channel
  typedef struct packed {
    logic [7:0]         dac_code;
    logic               direction_source;
    ldc_full_scale_type full_scale_select;
  } ldc_channel_type;

  // Converter sample from the ramp logic
  typedef struct packed {
    logic       valid;
    logic [7:0] code;
  } ldc_sample_type;

endpackage : ldc_pkg

/* ldc_code_select_monitor.sv */
// Purpose: Port-level checks of the code selector
// Assumes: Control images are rebuilt from observed writes
// Notes:   Zero-hold check stops at the first sample, so it stays conservative
`timescale 1ns/10ps
module ldc_code_select_monitor (
  // Clock, reset and register port
  input wire logic                     i_clk,
  input wire logic                     i_reset_n,
  input wire logic [8:0]               i_addr,
  input wire logic [7:0]               i_wdata,
  input wire logic                     i_write,
  input wire logic                     i_read,
  input wire logic [7:0]               o_rdata,
  // Converter and channels
  input wire ldc_pkg::ldc_sample_type  i_sample,
  input wire logic                     o_reference_source_select,
  input wire logic                     o_converter_input_select,
  input wire ldc_pkg::ldc_channel_type o_channel1,
  input wire ldc_pkg::ldc_channel_type o_channel2
);
  logic [7:0] c [0:7];
  logic       seen;
  wire        in_ctrl = (i_addr >= ldc_pkg::ADDR_CTRL0) && (i_addr <= ldc_pkg::ADDR_CTRL5);
  wire  [7:0] rb = c[i_addr[2:0]];
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int k = 0; k < 8; k++) c[k] <= 8'h00;
      seen <= 1'b0;
    end else begin
      if (i_write && in_ctrl) c[i_addr[2:0]] <= i_wdata;
      if (i_sample.valid) seen <= 1'b1;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  sequence s_ctrl_read;
    i_read && in_ctrl;
  endsequence
  property p_ref; o_reference_source_select == c[0][0]; endproperty
  property p_inp; o_converter_input_select == c[0][1]; endproperty
  property p_dir; o_channel1.direction_source == c[0][3] && o_channel2.direction_source == c[0][4]; endproperty
  property p_fs; o_channel1.full_scale_select == c[5][1:0] && o_channel2.full_scale_select == c[5][3:2]; endproperty
  property p_dac1; $past(c[5][5]) |-> o_channel1.dac_code == $past(c[3]); endproperty
  property p_dac2; $past(c[5][7]) |-> o_channel2.dac_code == $past(c[4]); endproperty
  property p_zero;
    (seen || $past(c[5][5]) || $past(c[5][4]) || o_channel1.dac_code == 8'h00) &&
    (seen || $past(c[5][7]) || $past(c[5][6]) || o_channel2.dac_code == 8'h00);
  endproperty
  property p_rb; s_ctrl_read |=> o_rdata == $past(rb); endproperty
  a_ref: assert property (p_ref) else $error("reference select wrong");
  a_inp: assert property (p_inp) else $error("input select wrong");
  a_dir: assert property (p_dir) else $error("direction wrong");
  a_fs: assert property (p_fs) else $error("full scale wrong");
  a_dac1: assert property (p_dac1) else $error("dac1 direct byte wrong");
  a_dac2: assert property (p_dac2) else $error("dac2 direct byte wrong");
  a_zero: assert property (p_zero) else $error("dac code not held at zero");
  a_rb: assert property (p_rb) else $error("control readback wrong");
endmodule : ldc_code_select_monitor
bind ldc_code_select ldc_code_select_monitor u_mon (.i_clk, .i_reset_n, .i_addr, .i_wdata, .i_write, .i_read,
  .o_rdata, .i_sample, .o_reference_source_select, .o_converter_input_select, .o_channel1, .o_channel2);

/* ldc_converter_model.sv */
// Purpose: Ramp converter stand-in, one sample per start pulse
// Assumes: Start is a one-cycle pulse from the bench
// Notes:   Code flips between samples so a stale value cannot pass
`timescale 1ns/10ps
module ldc_converter_model (
  // Clock and control
  input  wire logic              i_clk,
  input  wire logic              i_reset_n,
  input  wire logic              i_start,
  input  wire logic [7:0]        i_level,
  // Sample out
  output ldc_pkg::ldc_sample_type o_sample
);
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_sample <= '0;
    end else begin
      o_sample.valid <= i_start;
      o_sample.code  <= i_start ? i_level : ~o_sample.code;
    end
  end
endmodule : ldc_converter_model

/* tb_ldc_code_select.sv */
// Purpose: Self-checking bench for the code selector
// Assumes: Each conv call yields exactly one converter sample
// Notes:   Tables are filled first because they power up undefined
`timescale 1ns/10ps
module tb_ldc_code_select;
  logic                     clk = 1'b0;
  logic                     rst_n = 1'b0;
  logic                     wr = 1'b0;
  logic                     rd = 1'b0;
  logic                     start = 1'b0;
  logic [8:0]               addr = 9'h000;
  logic [7:0]               wd = 8'h00;
  logic [7:0]               lvl = 8'h00;
  logic [7:0]               rdata, rv, a, b, c, v;
  logic [7:0]               tbl [0:127];
  logic                     ref_sel, in_sel;
  ldc_pkg::ldc_sample_type  smp;
  ldc_pkg::ldc_channel_type ch1, ch2;
  int                       bad_count = 0;
  int                       cmp_count = 0;
  int                       cyc = 0;
  ldc_code_select uut (.i_clk(clk), .i_reset_n(rst_n), .i_addr(addr), .i_wdata(wd), .i_write(wr), .i_read(rd),
    .o_rdata(rdata), .i_sample(smp), .o_reference_source_select(ref_sel), .o_converter_input_select(in_sel),
    .o_channel1(ch1), .o_channel2(ch2));
  ldc_converter_model u_adc (.i_clk(clk), .i_reset_n(rst_n), .i_start(start), .i_level(lvl), .o_sample(smp));
  always #5 clk = ~clk;
  function automatic logic [7:0] lut(input int ch, input logic [5:0] r);
    return tbl[ch * 64 + r];
  endfunction : lut
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wreg(input logic [8:0] ad, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= ad;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [8:0] ad, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= ad;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rreg
  // Two edges cover the one-cycle register and the one-cycle DAC stage
  task automatic pause;
    repeat (2) @(posedge clk);
    #1;
  endtask : pause
  task automatic conv(input logic [7:0] code);
    @(posedge clk);
    start <= 1'b1;
    lvl <= code;
    @(posedge clk);
    start <= 1'b0;
    pause();
  endtask : conv
  task automatic conclude;
    $display("Mismatches %0d, compares %0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      conclude();
    end
  end
  initial begin
    void'($urandom(32'h882e));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk("ref", {7'h00, ref_sel}, 8'h00);
    chk("input", {7'h00, in_sel}, 8'h00);
    chk("dac1", ch1.dac_code, 8'h00);
    chk("dac2 reset", ch2.dac_code, 8'h00);
    for (int k = 0; k < 128; k++) begin
      tbl[k] = 8'($urandom);
      wreg(ldc_pkg::TABLE1_BASE + 9'(k), tbl[k]);
    end
    for (int k = 0; k < 128; k++) begin
      rreg(ldc_pkg::TABLE1_BASE + 9'(k), rv);
      chk("table", rv, tbl[k]);
    end
    rreg(9'h088, rv);
    chk("unmapped", rv, 8'h00);
    wreg(ldc_pkg::ADDR_STATUS, 8'h5a);
    rreg(ldc_pkg::ADDR_STATUS, rv);
    chk("status ro", rv, 8'h00);
    a = 8'($urandom);
    b = a ^ 8'h40;
    repeat (3) conv(a);
    conv(b);
    repeat (3) conv(a);
    rreg(ldc_pkg::ADDR_STATUS, rv);
    chk("status early", rv, 8'h00);
    chk("dac2 hold", ch2.dac_code, 8'h00);
    conv(a);
    rreg(ldc_pkg::ADDR_STATUS, rv);
    chk("status", rv, a);
    chk("dac1", ch1.dac_code, lut(0, a[7:2]));
    chk("dac2", ch2.dac_code, lut(1, a[7:2]));
    conv(a ^ 8'h03);
    conv(b);
    rreg(ldc_pkg::ADDR_STATUS, rv);
    chk("status hold", rv, a ^ 8'h03);
    wreg(ldc_pkg::ADDR_CTRL0, 8'h04);
    for (int k = 0; k < 10; k++) begin
      c = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($urandom);
      conv(c);
      rreg(ldc_pkg::ADDR_STATUS, rv);
      chk("bypass", rv, c);
      chk("dac1 row", ch1.dac_code, lut(0, c[7:2]));
    end
    a = 8'($urandom);
    b = 8'($urandom);
    wreg(ldc_pkg::ADDR_CTRL1, a);
    wreg(ldc_pkg::ADDR_CTRL2, b);
    wreg(ldc_pkg::ADDR_CTRL5, 8'h50);
    pause();
    chk("row1", ch1.dac_code, lut(0, a[5:0]));
    chk("row2", ch2.dac_code, lut(1, b[5:0]));
    rreg(ldc_pkg::ADDR_CTRL1, rv);
    chk("ctrl1 rb", rv, a);
    rreg(ldc_pkg::ADDR_CTRL2, rv);
    chk("ctrl2 rb", rv, b);
    wreg(ldc_pkg::ADDR_CTRL3, b);
    wreg(ldc_pkg::ADDR_CTRL4, a);
    wreg(ldc_pkg::ADDR_CTRL5, 8'h20);
    conv(c ^ 8'h80);
    chk("byte1", ch1.dac_code, b);
    chk("conv2", ch2.dac_code, lut(1, c[7:2] ^ 6'h20));
    wreg(ldc_pkg::ADDR_CTRL5, 8'hf0);
    pause();
    chk("byte2", ch2.dac_code, a);
    for (int k = 0; k < 4; k++) begin
      v = 8'($urandom);
      wreg(ldc_pkg::ADDR_CTRL5, {4'h0, 2'(k), 2'(3 - k)});
      wreg(ldc_pkg::ADDR_CTRL0, v);
      #1;
      chk("fs1", {6'h00, ch1.full_scale_select}, 8'(3 - k));
      chk("fs2", {6'h00, ch2.full_scale_select}, 8'(k));
      chk("ref", {7'h00, ref_sel}, {7'h00, v[0]});
      chk("input", {7'h00, in_sel}, {7'h00, v[1]});
      chk("dirs", {6'h00, ch2.direction_source, ch1.direction_source}, {6'h00, v[4:3]});
      rreg(ldc_pkg::ADDR_CTRL0, rv);
      chk("ctrl0 rb", rv, v);
      rreg(ldc_pkg::ADDR_CTRL5, rv);
      chk("ctrl5 rb", rv, {4'h0, 2'(k), 2'(3 - k)});
    end
    conclude();
  end
endmodule : tb_ldc_code_select
